// ---- bpts_defines.vh ----
// Purpose: constants for the backup power timestamp block
// Assumes: apb byte addresses, 8-bit registers in low bits of a word
// Notes: offsets 0x18..0x1f are register indices, byte address = 4x
`ifndef BPTS_DEFINES_VH
`define BPTS_DEFINES_VH
`define BPTS_IDX_PD_MIN 8'h18
`define BPTS_IDX_PD_HOUR 8'h19
`define BPTS_IDX_PD_DATE 8'h1a
`define BPTS_IDX_PD_MTH 8'h1b
`define BPTS_IDX_PU_MIN 8'h1c
`define BPTS_IDX_PU_HOUR 8'h1d
`define BPTS_IDX_PU_DATE 8'h1e
`define BPTS_IDX_PU_MTH 8'h1f
`define BPTS_IDX_CTRL 8'h20
`define BPTS_IDX_STAT 8'h21
`define BPTS_IDX_IRQ_STAT 8'h22
`define BPTS_IDX_IRQ_MASK 8'h23
`define BPTS_CTRL_VBAT_BIT 0
`define BPTS_CTRL_CRS_BIT 1
`define BPTS_CTRL_SQW_BIT 2
`define BPTS_STAT_FAIL_BIT 0
`define BPTS_STAT_BACKUP_BIT 1
`define BPTS_STAT_OSC_BIT 2
`define BPTS_IRQ_DOWN_BIT 0
`define BPTS_IRQ_UP_BIT 1
`define BPTS_MIN_MASK 8'h7f
`define BPTS_HOUR_MASK 8'h7f
`define BPTS_DATE_MASK 8'h3f
`define BPTS_MTH_MASK 8'hff
`define BPTS_RST_BYTE 8'h00
`define BPTS_RST_WORD 32'h0000_0000
`endif

// ---- bpts_top.v ----
// Purpose: supply switchover and power-fail timestamp logic with apb access
// Assumes: supply comparator and oscillator status arrive asynchronously
// Notes: serial port, alarms, trim arithmetic live outside this block
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`include "bpts_defines.vh"
module bpts_top (
    input wire clock,
    input wire resetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire main_below_threshold,
    input wire oscillator_running,
    input wire [7:0] live_minutes,
    input wire [7:0] live_hours,
    input wire [7:0] live_date,
    input wire [7:0] live_month,
    input wire square_wave_in,
    input wire coarse_trim_wave_in,
    output reg core_on_backup,
    output reg serial_enable,
    output reg watchdog_enable,
    output reg event_detect_enable,
    output reg timekeeping_enable,
    output reg clock_output_pin,
    output reg irq
);
    // three-stage synchronisers for asynchronous supply and oscillator status
    reg [2:0] below_sync_reg;
    reg [2:0] osc_sync_reg;
    reg below_state_reg;
    reg osc_state_reg;
    reg backup_supply_enable_reg;
    reg coarse_trim_enable_reg;
    reg square_wave_enable_reg;
    reg power_fail_flag_reg;
    reg [7:0] stamp_reg [0:7];
    reg [1:0] irq_stat_reg;
    reg [1:0] irq_mask_reg;
    reg prev_backup_reg;
    // up stamp is owed only to an outage whose down stamp was logged
    reg up_pending_reg;
    wire apb_access;
    wire apb_write;
    wire [7:0] idx;
    wire addr_ok;
    wire go_backup;
    wire go_down;
    wire go_up;
    wire clear_fail;
    reg [31:0] rd_next;
    integer i;

    function is_stamp;
        input [7:0] a;
        begin
            is_stamp = (a >= `BPTS_IDX_PD_MIN) && (a <= `BPTS_IDX_PU_MTH);
        end
    endfunction

    function [7:0] stamp_mask;
        input [1:0] field;
        begin
            case (field)
                2'd0: stamp_mask = `BPTS_MIN_MASK;
                2'd1: stamp_mask = `BPTS_HOUR_MASK;
                2'd2: stamp_mask = `BPTS_DATE_MASK;
                default: stamp_mask = `BPTS_MTH_MASK;
            endcase
        end
    endfunction

    assign apb_access = psel && penable;
    assign apb_write = apb_access && pwrite;
    assign idx = paddr[9:2];
    assign addr_ok = (paddr[1:0] == 2'b00) && (paddr[31:10] == 22'd0) &&
        (is_stamp(idx) || idx == `BPTS_IDX_CTRL || idx == `BPTS_IDX_STAT ||
        idx == `BPTS_IDX_IRQ_STAT || idx == `BPTS_IDX_IRQ_MASK);

    // disabled backup leaves the core on main: its state is undefined anyway
    assign go_backup = below_state_reg && backup_supply_enable_reg;
    assign go_down = go_backup && !prev_backup_reg;
    assign go_up = !go_backup && prev_backup_reg;
    assign clear_fail = apb_write && idx == `BPTS_IDX_STAT && addr_ok &&
        !pwdata[`BPTS_STAT_FAIL_BIT];

    always @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            below_sync_reg <= 3'b000;
            osc_sync_reg <= 3'b000;
            below_state_reg <= 1'b0;
            osc_state_reg <= 1'b0;
        end
        else
        begin
            below_sync_reg <= {below_sync_reg[1:0], main_below_threshold};
            osc_sync_reg <= {osc_sync_reg[1:0], oscillator_running};
            // change counts once second and third stages agree
            if (below_sync_reg[1] == below_sync_reg[2])
                below_state_reg <= below_sync_reg[2];
            if (osc_sync_reg[1] == osc_sync_reg[2])
                osc_state_reg <= osc_sync_reg[2];
        end
    end

    always @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            prev_backup_reg <= 1'b0;
            core_on_backup <= 1'b0;
            serial_enable <= 1'b0;
            watchdog_enable <= 1'b0;
            event_detect_enable <= 1'b0;
            timekeeping_enable <= 1'b0;
            clock_output_pin <= 1'b0;
        end
        else
        begin
            prev_backup_reg <= go_backup;
            core_on_backup <= go_backup;
            // timekeeping, alarms and trim run from either supply
            timekeeping_enable <= 1'b1;
            serial_enable <= !go_backup;
            watchdog_enable <= !go_backup;
            event_detect_enable <= !go_backup;
            if (go_backup || !square_wave_enable_reg)
                clock_output_pin <= 1'b0;
            else if (coarse_trim_enable_reg)
                clock_output_pin <= coarse_trim_wave_in;
            else
                clock_output_pin <= square_wave_in;
        end
    end

    // control, flag, stamps and interrupt state
    always @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            backup_supply_enable_reg <= 1'b0;
            coarse_trim_enable_reg <= 1'b0;
            square_wave_enable_reg <= 1'b0;
            power_fail_flag_reg <= 1'b0;
            up_pending_reg <= 1'b0;
            irq_stat_reg <= 2'b00;
            irq_mask_reg <= 2'b00;
            for (i = 0; i < 8; i = i + 1)
                stamp_reg[i] <= `BPTS_RST_BYTE;
        end
        else
        begin
            if (apb_write && addr_ok)
            begin
                if (idx == `BPTS_IDX_CTRL)
                begin
                    backup_supply_enable_reg <=
                        pwdata[`BPTS_CTRL_VBAT_BIT];
                    coarse_trim_enable_reg <= pwdata[`BPTS_CTRL_CRS_BIT];
                    square_wave_enable_reg <= pwdata[`BPTS_CTRL_SQW_BIT];
                end
                if (idx == `BPTS_IDX_IRQ_MASK)
                    irq_mask_reg <= pwdata[1:0];
                if (is_stamp(idx))
                    stamp_reg[idx[2:0]] <= pwdata[7:0] &
                        stamp_mask(idx[1:0]);
            end
            if (clear_fail)
            begin
                power_fail_flag_reg <= 1'b0;
                up_pending_reg <= 1'b0;
                for (i = 0; i < 8; i = i + 1)
                    stamp_reg[i] <= `BPTS_RST_BYTE;
            end
            // logging only while flag clear; a capture beats a clear
            if (go_down && !power_fail_flag_reg)
            begin
                stamp_reg[0] <= live_minutes & `BPTS_MIN_MASK;
                stamp_reg[1] <= live_hours & `BPTS_HOUR_MASK;
                stamp_reg[2] <= live_date & `BPTS_DATE_MASK;
                stamp_reg[3] <= live_month;
                power_fail_flag_reg <= 1'b1;
                up_pending_reg <= 1'b1;
            end
            // power-up stamp pairs with the down stamp of the same outage
            if (go_up && up_pending_reg && !clear_fail)
            begin
                up_pending_reg <= 1'b0;
                stamp_reg[4] <= live_minutes & `BPTS_MIN_MASK;
                stamp_reg[5] <= live_hours & `BPTS_HOUR_MASK;
                stamp_reg[6] <= live_date & `BPTS_DATE_MASK;
                stamp_reg[7] <= live_month;
            end
            irq_stat_reg[`BPTS_IRQ_DOWN_BIT] <= go_down ||
                (irq_stat_reg[`BPTS_IRQ_DOWN_BIT] && !(apb_write &&
                addr_ok && idx == `BPTS_IDX_IRQ_STAT &&
                pwdata[`BPTS_IRQ_DOWN_BIT]));
            irq_stat_reg[`BPTS_IRQ_UP_BIT] <= go_up ||
                (irq_stat_reg[`BPTS_IRQ_UP_BIT] && !(apb_write &&
                addr_ok && idx == `BPTS_IDX_IRQ_STAT &&
                pwdata[`BPTS_IRQ_UP_BIT]));
        end
    end

    always @*
    begin
        rd_next = `BPTS_RST_WORD;
        if (is_stamp(idx))
            rd_next = {24'd0, stamp_reg[idx[2:0]]};
        else if (idx == `BPTS_IDX_CTRL)
            rd_next = {29'd0, square_wave_enable_reg,
                coarse_trim_enable_reg, backup_supply_enable_reg};
        else if (idx == `BPTS_IDX_STAT)
            rd_next = {29'd0, osc_state_reg, go_backup,
                power_fail_flag_reg};
        else if (idx == `BPTS_IDX_IRQ_STAT)
            rd_next = {30'd0, irq_stat_reg};
        else if (idx == `BPTS_IDX_IRQ_MASK)
            rd_next = {30'd0, irq_mask_reg};
    end

    // no wait state: answer registered in the setup phase
    always @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= `BPTS_RST_WORD;
            irq <= 1'b0;
        end
        else
        begin
            irq <= |(irq_stat_reg & irq_mask_reg);
            pready <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok;
            if (psel && !penable && !pwrite && addr_ok)
                prdata <= rd_next;
            else
                prdata <= `BPTS_RST_WORD;
        end
    end
endmodule // bpts_top

// ---- bpts_monitor.sv ----
// Purpose: port checker for bpts_top
// Assumes: one clock domain, async active-low reset
// Notes: bound to every bpts_top instance
`timescale 1ns/1ps
module bpts_monitor (
    input wire clock,
    input wire resetn,
    input wire psel,
    input wire penable,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire main_below_threshold,
    input wire core_on_backup,
    input wire serial_enable,
    input wire watchdog_enable,
    input wire event_detect_enable,
    input wire timekeeping_enable,
    input wire clock_output_pin,
    input wire irq
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_idle_data_zero: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("read data outside access");
    a_backup_quiet: assert property (core_on_backup |-> ##[0:1]
        (!serial_enable && !watchdog_enable && !event_detect_enable))
        else $error("port still served on backup");
    a_backup_keeps_time: assert property (
        core_on_backup |-> timekeeping_enable)
        else $error("timekeeping stopped on backup");
    a_clock_output_pin_off_backup: assert property (
        core_on_backup && $past(core_on_backup) |-> !clock_output_pin)
        else $error("clock output active on backup");
    a_main_returns: assert property (
        !main_below_threshold [*8] |-> !core_on_backup)
        else $error("core stays on backup with main up");
    cover property ($rose(core_on_backup));
    cover property ($fell(core_on_backup));
    cover property (pslverr);
    cover property (irq);
endmodule // bpts_monitor
bind bpts_top bpts_monitor mon_u (.clock(clock), .resetn(resetn),
    .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .main_below_threshold(main_below_threshold),
    .core_on_backup(core_on_backup), .serial_enable(serial_enable),
    .watchdog_enable(watchdog_enable), .irq(irq),
    .event_detect_enable(event_detect_enable),
    .timekeeping_enable(timekeeping_enable),
    .clock_output_pin(clock_output_pin));

// ---- bpts_top_tb.sv ----
// Purpose: self-checking bench for bpts_top
// Assumes: apb byte address is four times the register index
// Notes: supply changes are slow levels, live counters random bcd
`timescale 1ns/1ps
`include "bpts_defines.vh"
`define CHK(g, e) chk(32'(g), 32'(e))
module bpts_top_tb;
    logic clock = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic main_below_threshold = 0, oscillator_running = 0, err;
    logic square_wave_in = 1, coarse_trim_wave_in = 1;
    logic [31:0] paddr = '0, pwdata = '0, prdata, rd, d;
    logic [7:0] lv[4] = '{default: '0};
    logic [7:0] msk[4] = '{8'h7f, 8'h7f, 8'h3f, 8'hff};
    logic [7:0] exp_s[8];
    logic pready, pslverr, core_on_backup, serial_enable, watchdog_enable;
    logic event_detect_enable, timekeeping_enable, clock_output_pin, irq;
    int miscompares = 0, n_checks = 0, cyc = 0, k;
    bpts_top dut_u (.clock(clock), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .main_below_threshold(main_below_threshold),
        .oscillator_running(oscillator_running), .live_minutes(lv[0]),
        .live_hours(lv[1]), .live_date(lv[2]), .live_month(lv[3]),
        .square_wave_in(square_wave_in),
        .coarse_trim_wave_in(coarse_trim_wave_in),
        .core_on_backup(core_on_backup), .serial_enable(serial_enable),
        .watchdog_enable(watchdog_enable), .irq(irq),
        .event_detect_enable(event_detect_enable),
        .timekeeping_enable(timekeeping_enable),
        .clock_output_pin(clock_output_pin));
    always #50 clock = ~clock;
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task wrap_up;
        if (miscompares == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // request held until ready seen, released only after that edge
    task apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
        int n;
        @(posedge clock);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= {22'h0, idx, 2'h0};
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'h1;
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (pready !== 1'h1 && n < 20);
        if (pready !== 1'h1)
            miscompares++;
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task rd_stamps(input int n);
        for (int i = 0; i < n; i++)
        begin
            apb(1'h0, `BPTS_IDX_PD_MIN + 8'(i), '0);
            `CHK(rd, exp_s[i]);
        end
    endtask
    task wait_core(input logic v);
        k = 0;
        while (core_on_backup !== v && k < 20)
        begin
            @(negedge clock);
            k++;
        end
        `CHK(core_on_backup, v);
    endtask
    task set_live;
        @(posedge clock);
        lv[0] <= {1'h0, 3'($urandom_range(5)), 4'($urandom_range(9))};
        lv[1] <= $urandom_range(1) ? {3'h3, 1'($urandom), 4'($urandom_range(2))}
            : {2'h0, 2'($urandom_range(2)), 4'($urandom_range(3))};
        lv[2] <= {2'h0, 2'($urandom_range(3)), 4'($urandom_range(9))};
        lv[3] <= {3'($urandom_range(7, 1)), 1'h0, 4'($urandom_range(9, 1))};
    endtask
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            miscompares++;
            wrap_up;
        end
    end
    initial
    begin
        void'($urandom(32'hc682));
        repeat (3) @(posedge clock);
        resetn <= 1'h1;
        for (int i = 0; i < 8; i++)
        begin
            apb(1'h0, `BPTS_IDX_PD_MIN + 8'(i), '0);
            `CHK(rd, 0);
            d = $urandom;
            apb(1'h1, `BPTS_IDX_PD_MIN + 8'(i), d);
            apb(1'h0, `BPTS_IDX_PD_MIN + 8'(i), '0);
            `CHK(rd, d & msk[i % 4]);
            exp_s[i] = '0;
        end
        apb(1'h0, 8'h40, '0);
        `CHK({err, rd[30:0]}, 32'h8000_0000);
        apb(1'h1, `BPTS_IDX_STAT, '0);
        rd_stamps(8);
        oscillator_running <= 1'h1;
        rd = '0;
        k = 0;
        while (rd[2] !== 1'h1 && k < 20)
        begin
            apb(1'h0, `BPTS_IDX_STAT, '0);
            k++;
        end
        `CHK(rd[2], 1);
        apb(1'h1, `BPTS_IDX_IRQ_MASK, 32'h0000_0003);
        apb(1'h1, `BPTS_IDX_CTRL, 32'h0000_0007);
        repeat (2) @(negedge clock);
        `CHK(clock_output_pin, 1);
        for (int p = 0; p < 2; p++)
        begin
            set_live;
            main_below_threshold <= 1'h1;
            @(negedge clock);
            for (int j = 0; j < 4 && p == 0; j++)
                exp_s[j] = lv[j];
            wait_core(1'h1);
            repeat (2) @(negedge clock);
            `CHK({serial_enable, watchdog_enable, event_detect_enable,
                clock_output_pin, timekeeping_enable, irq}, 3);
            set_live;
            main_below_threshold <= 1'h0;
            @(negedge clock);
            for (int j = 0; j < 4 && p == 0; j++)
                exp_s[j + 4] = lv[j];
            wait_core(1'h0);
            rd_stamps(8);
        end
        apb(1'h0, `BPTS_IDX_STAT, '0);
        `CHK(rd[0], 1);
        apb(1'h0, `BPTS_IDX_IRQ_STAT, '0);
        `CHK(rd[1:0], 3);
        apb(1'h1, `BPTS_IDX_IRQ_STAT, 32'h0000_0003);
        apb(1'h1, `BPTS_IDX_STAT, '0);
        exp_s = '{default: '0};
        rd_stamps(8);
        `CHK(irq, 0);
        apb(1'h1, `BPTS_IDX_CTRL, '0);
        main_below_threshold <= 1'h1;
        repeat (10) @(negedge clock);
        `CHK(core_on_backup, 0);
        wrap_up;
    end
endmodule // bpts_top_tb
